/* hdl/srpmc_params.svh */
// constants for the sleep regulator power-mode controller
// assumes inclusion by bare name from design files
`ifndef SRPMC_PARAMS_SVH
`define SRPMC_PARAMS_SVH

`define SRPMC_ADDR_W 4
`define SRPMC_REG_CTRL 4'h0
`define SRPMC_REG_STATUS 4'h1
`define SRPMC_REG_PERIPH 4'h2
`define SRPMC_CTRL_FIXED_BIT 0
`define SRPMC_CTRL_LPSEL_BIT 1
`define SRPMC_CTRL_RESET 8'h01
`define SRPMC_WAKE_DELAY_NS 10000
`define SRPMC_CLK_PERIOD_NS 100
`define SRPMC_CAP_CHARGE_NS 100000

`endif

/* hdl/srpmc_pkg.sv */
// types for the sleep regulator power-mode controller
// assumes srpmc_params.svh sits on the include path
`include "srpmc_params.svh"

package srpmc_pkg;

	typedef enum logic [1:0] {
		SRPMC_RUN,
		SRPMC_SLEEP,
		SRPMC_SETTLE
	} srpmc_state_t;

	// enabled sleep-capable peripherals
	typedef struct packed {
		logic brownoutReset;
		logic watchdog;
		logic pinChangeInterrupt;
		logic sixteenBitTimerExt;
		logic captureMode;
		logic otherPeriph;
	} srpmc_periph_t;

	typedef struct packed {
		logic [`SRPMC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} srpmc_bus_t;

endpackage

/* hdl/srpmc_sleep_regulator.sv */
// sleep regulator power-mode controller: regulator low-power request,
// wake settle delay, power-up capacitor charge hold and register port
// assumes sleep request/wake come from core logic on ref_clk; pins are synchronised here
`timescale 1ns/100ps
`include "srpmc_params.svh"

// Overview of operation
// - only the sleep instruction enters power-down
// - normal select keeps regulator normal, fast wake
// - low-power wake adds settle delay
// - incompatible peripheral forces normal regulation
// - listed peripherals allow low-power sleep
// - control bit 1 selects low-power, resets 0
// - bit 0 reads one, bits 7-2 zero
// - unregulated variant: no select, no delay
// - regulator always on, no software switch
// - config bit low routes regulator to pin
// - hold reset until capacitor charged
module srpmc_sleep_regulator #(
	parameter bit REGULATED = 1'b1,
	parameter int WAKE_CYCLES = (`SRPMC_WAKE_DELAY_NS + `SRPMC_CLK_PERIOD_NS - 1) / `SRPMC_CLK_PERIOD_NS,
	parameter int CAP_CYCLES = (`SRPMC_CAP_CHARGE_NS + `SRPMC_CLK_PERIOD_NS - 1) / `SRPMC_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire srpmc_pkg::srpmc_bus_t bus,
	output logic [7:0] rdata,
	// core sleep control
	input wire logic sleepInstr,
	input wire logic wakeEvent,
	output logic cpuClkEn,
	output logic inSleep,
	// peripherals enabled in sleep
	input wire srpmc_pkg::srpmc_periph_t periphEn,
	// configuration and analog side
	input wire logic regulator_cap_pin_en_n,
	input wire logic capCharged,
	output logic regulatorLowPower,
	output logic regulatorEnable,
	output logic regulator_cap_pin,
	output logic chargeSourceOn,
	output logic deviceResetHold
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic capMeta_q, capSync_q;
	logic capEnMeta_q, capEnSync_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			capMeta_q <= 1'b0;
			capSync_q <= 1'b0;
			capEnMeta_q <= 1'b1;
			capEnSync_q <= 1'b1;
		end else begin
			capMeta_q <= capCharged;
			capSync_q <= capMeta_q;
			capEnMeta_q <= regulator_cap_pin_en_n;
			capEnSync_q <= capEnMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// power-up capacitor charge hold
	// ----------------------------------------------------------------
	logic holdRst_q;
	logic [$clog2(CAP_CYCLES+1)-1:0] capCnt_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			holdRst_q <= 1'b1;
			capCnt_q <= '0;
		end else if (holdRst_q) begin
			if (capSync_q && capCnt_q == ($clog2(CAP_CYCLES+1))'(CAP_CYCLES - 1)) begin
				holdRst_q <= 1'b0;
			end
			if (capCnt_q != ($clog2(CAP_CYCLES+1))'(CAP_CYCLES - 1)) begin
				capCnt_q <= capCnt_q + 1'b1;
			end
		end
	end

	assign deviceResetHold = holdRst_q;
	assign chargeSourceOn = holdRst_q;
	assign regulatorEnable = REGULATED;
	assign regulator_cap_pin = ~capEnSync_q & REGULATED;

	// ----------------------------------------------------------------
	// checks: reset hold and pin routing
	// ----------------------------------------------------------------
	localparam int CAP_W = $clog2(CAP_CYCLES+1);
	localparam logic [CAP_W-1:0] CAP_LAST = CAP_W'(CAP_CYCLES - 1);

	cap_pin_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
		!$past(rst, 2) |-> regulator_cap_pin == (REGULATED && !$past(regulator_cap_pin_en_n, 2)))
		else $error("pin routing does not follow config bit");

	cap_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(deviceResetHold) |-> $past(capSync_q) && $past(capCnt_q) == CAP_LAST)
		else $error("reset hold released before charge");

	cap_count_a: assert property (@(posedge ref_clk) disable iff (rst)
		holdRst_q && capCnt_q != CAP_LAST |=> capCnt_q == $past(capCnt_q) + 1'b1)
		else $error("charge counter skipped");

	cap_cnt_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		capCnt_q == CAP_LAST |=> capCnt_q == CAP_LAST)
		else $error("charge counter left its end value");

	hold_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		!deviceResetHold |=> !deviceResetHold)
		else $error("reset hold came back without reset");

	hold_clk_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		deviceResetHold |-> !cpuClkEn && !inSleep)
		else $error("core active during reset hold");

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic lpSel_q;
	logic fixedOne_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lpSel_q <= 1'b0;
			fixedOne_q <= 1'b1;
		end else if (bus.wr && bus.addr == `SRPMC_REG_CTRL && REGULATED) begin
			lpSel_q <= bus.wdata[`SRPMC_CTRL_LPSEL_BIT];
			fixedOne_q <= 1'b1;
		end
	end

	sel_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(bus.wr && bus.addr == `SRPMC_REG_CTRL) |=> $stable(lpSel_q))
		else $error("select changed without a write");

	sel_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_CTRL |=> rdata[`SRPMC_CTRL_LPSEL_BIT] == $past(lpSel_q))
		else $error("select read back wrong");

	// ----------------------------------------------------------------
	// low-power request
	// ----------------------------------------------------------------
	srpmc_pkg::srpmc_state_t state_q;
	logic incompatible;
	logic lpRequest;

	// only listed peripherals tolerate low-power regulation
	assign incompatible = periphEn.otherPeriph;
	assign lpRequest = REGULATED && lpSel_q && state_q == srpmc_pkg::SRPMC_SLEEP && !incompatible;
	assign regulatorLowPower = lpRequest;

	// ----------------------------------------------------------------
	// checks: low-power request
	// ----------------------------------------------------------------
	lp_only_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
		!inSleep |-> !regulatorLowPower)
		else $error("low power outside sleep");

	lp_needs_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		!lpSel_q |-> !regulatorLowPower)
		else $error("low power without select");

	listed_allow_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep && REGULATED && lpSel_q && !periphEn.otherPeriph && (periphEn.brownoutReset ||
		periphEn.watchdog || periphEn.pinChangeInterrupt || periphEn.sixteenBitTimerExt ||
		periphEn.captureMode) |-> regulatorLowPower)
		else $error("listed peripheral blocked low power");

	normal_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep && !lpSel_q |-> !regulatorLowPower)
		else $error("normal select left regulator low");

	// ----------------------------------------------------------------
	// sleep and wake sequencer
	// ----------------------------------------------------------------
	logic [$clog2(WAKE_CYCLES+1)-1:0] wakeCnt_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= srpmc_pkg::SRPMC_RUN;
			wakeCnt_q <= '0;
		end else begin
			unique case (state_q)
				srpmc_pkg::SRPMC_RUN: begin
					if (sleepInstr && !holdRst_q) begin
						state_q <= srpmc_pkg::SRPMC_SLEEP;
					end
				end
				srpmc_pkg::SRPMC_SLEEP: begin
					if (wakeEvent) begin
						if (lpRequest) begin
							state_q <= srpmc_pkg::SRPMC_SETTLE;
							wakeCnt_q <= '0;
						end else begin
							state_q <= srpmc_pkg::SRPMC_RUN;
						end
					end
				end
				srpmc_pkg::SRPMC_SETTLE: begin
					if (wakeCnt_q == ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES - 1)) begin
						state_q <= srpmc_pkg::SRPMC_RUN;
					end else begin
						wakeCnt_q <= wakeCnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	assign cpuClkEn = state_q == srpmc_pkg::SRPMC_RUN && !holdRst_q;
	assign inSleep = state_q == srpmc_pkg::SRPMC_SLEEP;

	// ----------------------------------------------------------------
	// checks: sleep and wake sequencer
	// ----------------------------------------------------------------
	localparam int WAKE_W = $clog2(WAKE_CYCLES+1);
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);

	sequence settleDone_s;
		state_q == srpmc_pkg::SRPMC_SETTLE && wakeCnt_q == WAKE_LAST;
	endsequence

	hold_no_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
		holdRst_q && state_q == srpmc_pkg::SRPMC_RUN |=> state_q == srpmc_pkg::SRPMC_RUN)
		else $error("sleep taken during reset hold");

	sleep_instr_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == srpmc_pkg::SRPMC_RUN && !sleepInstr |=> state_q == srpmc_pkg::SRPMC_RUN)
		else $error("run left without instruction");

	sleep_stay_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep && !wakeEvent |=> inSleep)
		else $error("sleep left without wake");

	clk_off_sleep_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep |-> !cpuClkEn)
		else $error("core clock running in sleep");

	settle_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == srpmc_pkg::SRPMC_SETTLE |-> !cpuClkEn && !regulatorLowPower)
		else $error("settle with clock or low power");

	settle_count_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == srpmc_pkg::SRPMC_SETTLE && wakeCnt_q != WAKE_LAST |=>
		state_q == srpmc_pkg::SRPMC_SETTLE && wakeCnt_q == $past(wakeCnt_q) + 1'b1)
		else $error("settle count broken");

	settle_len_a: assert property (@(posedge ref_clk) disable iff (rst)
		settleDone_s |=> cpuClkEn)
		else $error("settle did not end on time");

	wake_cnt_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == srpmc_pkg::SRPMC_SETTLE |-> wakeCnt_q <= WAKE_LAST)
		else $error("settle count out of range");

	normal_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep && wakeEvent && !lpRequest |=> state_q == srpmc_pkg::SRPMC_RUN)
		else $error("normal wake did not run");

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`SRPMC_REG_CTRL: rdata <= {6'h00, lpSel_q, fixedOne_q};
				`SRPMC_REG_STATUS: rdata <= {4'h0, holdRst_q, regulatorLowPower, state_q};
				`SRPMC_REG_PERIPH: rdata <= {2'h0, periphEn};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!bus.rd |=> rdata == 8'h00)
		else $error("read data without read");

	unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr != `SRPMC_REG_CTRL && bus.addr != `SRPMC_REG_STATUS &&
		bus.addr != `SRPMC_REG_PERIPH |=> rdata == 8'h00)
		else $error("unmapped read not zero");

	periph_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_PERIPH |=> rdata == {2'h0, $past(periphEn)})
		else $error("peripheral read wrong");

	status_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_STATUS |=> rdata[3] == $past(holdRst_q))
		else $error("status hold bit wrong");

	status_state_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_STATUS |=> rdata[1:0] == $past(state_q))
		else $error("status state wrong");

	status_lp_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_STATUS |=> rdata[2] == $past(regulatorLowPower))
		else $error("status low-power bit wrong");

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence lpWake_s;
		state_q == srpmc_pkg::SRPMC_SLEEP && wakeEvent && lpRequest;
	endsequence

	sequence settleStart_s;
		state_q == srpmc_pkg::SRPMC_SETTLE && wakeCnt_q == '0;
	endsequence

	settle_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		lpWake_s |=> settleStart_s) else $error("settle count not restarted");

	sleep_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(inSleep) |-> $past(sleepInstr)) else $error("sleep entered without instruction");
	normal_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == srpmc_pkg::SRPMC_SLEEP && wakeEvent && !lpRequest |=> cpuClkEn) else $error("normal wake slow");
	settle_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
		lpWake_s |=> !cpuClkEn [*1] ##0 !regulatorLowPower) else $error("low-power wake not delayed");
	settle_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		lpWake_s |-> ##[1:1000] cpuClkEn) else $error("settle never ends");
	periph_force_a: assert property (@(posedge ref_clk) disable iff (rst)
		periphEn.otherPeriph |-> !regulatorLowPower) else $error("low power with incompatible peripheral");
	lp_request_a: assert property (@(posedge ref_clk) disable iff (rst)
		inSleep && lpSel_q && !periphEn.otherPeriph && REGULATED |-> regulatorLowPower)
		else $error("low-power request missing");
	ctrl_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.rd && bus.addr == `SRPMC_REG_CTRL |=> rdata[0] && rdata[7:2] == 6'h00) else $error("fixed bits wrong");
	sel_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		bus.wr && bus.addr == `SRPMC_REG_CTRL && REGULATED |=> lpSel_q == $past(bus.wdata[1])) else $error("select lost");
	cap_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!capSync_q |=> deviceResetHold || !$past(deviceResetHold)) else $error("reset released early");

endmodule

/* test/srpmc_core_model.sv */
// core sleep and wake control model facing the regulator controller
// assumes the bench raises doSleep/doWake after a rising edge of ref_clk
`timescale 1ns/100ps

module srpmc_core_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bench commands
	input wire logic doSleep,
	input wire logic doWake,
	// controller status
	input wire logic cpuClkEn,
	input wire logic inSleep,
	// requests to the controller
	output logic sleepInstr,
	output logic wakeEvent
);
	// sleep is requested only by a single executed sleep instruction
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sleepInstr <= 1'b0;
		end else begin
			sleepInstr <= doSleep && cpuClkEn && !sleepInstr;
		end
	end

	// wake source follows doWake one cycle late, and only while the core sleeps
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeEvent <= 1'b0;
		end else begin
			wakeEvent <= doWake && inSleep;
		end
	end
endmodule

/* test/tb_top.sv */
// bench for the sleep regulator controller: register port, sleep and wake, reset hold
// assumes the core model in srpmc_core_model.sv and short counts of 4
`timescale 1ns/100ps
`include "srpmc_params.svh"

module tb_top;
	localparam int WAKE = 4;
	localparam int CAP = 4;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	srpmc_pkg::srpmc_bus_t bus = '0;
	srpmc_pkg::srpmc_periph_t periphEn = '0;
	logic [7:0] rdata;
	logic doSleep = 1'b0, doWake = 1'b0, capCharged = 1'b0, capEnN = 1'b0;
	logic sleepInstr, wakeEvent, cpuClkEn, inSleep, lowPwr, regEn, capPin, chargeOn, resetHold;
	int error_cnt = 0, samples_checked = 0, n;

	srpmc_sleep_regulator #(.REGULATED(1'b1), .WAKE_CYCLES(WAKE), .CAP_CYCLES(CAP)) dut (.ref_clk(ref_clk),
		.rst(rst), .bus(bus), .rdata(rdata), .sleepInstr(sleepInstr), .wakeEvent(wakeEvent), .cpuClkEn(cpuClkEn),
		.inSleep(inSleep), .periphEn(periphEn), .regulator_cap_pin_en_n(capEnN), .capCharged(capCharged),
		.regulatorLowPower(lowPwr), .regulatorEnable(regEn), .regulator_cap_pin(capPin),
		.chargeSourceOn(chargeOn), .deviceResetHold(resetHold));
	srpmc_core_model core (.ref_clk(ref_clk), .rst(rst), .doSleep(doSleep), .doWake(doWake),
		.cpuClkEn(cpuClkEn), .inSleep(inSleep), .sleepInstr(sleepInstr), .wakeEvent(wakeEvent));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	endtask

	task automatic bound(input int cnt, input int lim);
		if (cnt >= lim) begin
			error_cnt++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// sleep and check low power, then wake and check the edges from leaving sleep to a running clock against expCnt
	task automatic nap(input logic [7:0] expLow, input logic [7:0] expCnt);
		@(posedge ref_clk);
		doSleep <= 1'b1;
		for (n = 0; n < 20 && inSleep !== 1'b1; n++) @(posedge ref_clk) #1;
		bound(n, 20);
		chk(lowPwr, expLow);
		@(posedge ref_clk);
		doSleep <= 1'b0;
		doWake <= 1'b1;
		for (n = 0; n < 20 && inSleep !== 1'b0; n++) @(posedge ref_clk) #1;
		bound(n, 20);
		for (n = 0; n < 50 && cpuClkEn !== 1'b1; n++) @(posedge ref_clk) #1;
		bound(n, 50);
		chk(8'(n), expCnt);
		@(posedge ref_clk);
		doWake <= 1'b0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (CAP + 4) @(posedge ref_clk);
		#1 chk(resetHold, 1'b1);
		chk(chargeOn, 1'b1);
		rd(`SRPMC_REG_STATUS, 8'h08);
		@(posedge ref_clk);
		capCharged <= 1'b1;
		for (n = 0; n < CAP + 10 && resetHold !== 1'b0; n++) @(posedge ref_clk) #1;
		bound(n, CAP + 10);
		#1 chk(chargeOn, 1'b0);
		chk(regEn, 1'b1);
		chk(capPin, 1'b1);
		rd(`SRPMC_REG_CTRL, `SRPMC_CTRL_RESET);
		wr(`SRPMC_REG_CTRL, 8'hFF);
		rd(`SRPMC_REG_CTRL, 8'h03);
		wr(`SRPMC_REG_CTRL, 8'h00);
		rd(`SRPMC_REG_CTRL, 8'h01);
		rd(4'hF, 8'h00);
		periphEn <= 6'h3E;
		rd(`SRPMC_REG_PERIPH, 8'h3E);
		wr(`SRPMC_REG_CTRL, 8'h03);
		nap(8'h01, WAKE);
		periphEn <= 6'h3F;
		nap(8'h00, 8'h00);
		periphEn <= 6'h00;
		wr(`SRPMC_REG_CTRL, 8'h01);
		nap(8'h00, 8'h00);
		#1 chk(lowPwr, 1'b0);
		stop_test();
	end
endmodule
